/* File: testbench/pwmart_pins.sv */
`timescale 1ns/100ps
// far side: external count clock and the two capture inputs
module pwmart_pins (
   // clock
   input wire logic mclk,
   // pins toward the timer
   output logic ext_clk,
   output logic [1:0] cap
);
   // idle low until a scenario asks for events
   initial begin
      ext_clk = 1'h0;
      cap = 2'h0;
   end
   // counted input events
   // levels held four cycles so the synchroniser never misses one
   task pulse(input int n);
      repeat (n) begin
         @(posedge mclk) ext_clk <= 1'h1;
         repeat (4) @(posedge mclk);
         ext_clk <= 1'h0;
         repeat (4) @(posedge mclk);
      end
   endtask
   task set_cap(input int ch, input logic lv);
      @(posedge mclk) cap[ch] <= lv;
      repeat (4) @(posedge mclk);
   endtask
endmodule

/* File: testbench/pwmart_sva.sv */
`timescale 1ns/100ps
// port-level checks of the timer top
module pwmart_sva (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   // system state and pins
   input wire logic halt_mode,
   input wire logic [3:0] pwm_output_pin,
   input wire logic [3:0] pwm_output_oe_n,
   // requests
   input wire logic overflow_irq,
   input wire logic [1:0] capture_irq,
   input wire logic capture_wakeup
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // a level request may only drop shortly after a software access
   sequence s_access;
      $past(rd_stb) || $past(wr_stb) || $past(rd_stb, 2) || $past(wr_stb, 2);
   endsequence
   sequence s_csr_read;
      rd_stb && addr == pwmart_pkg::ADDR_CTRL_STATUS;
   endsequence
   // reads, enables, halt freeze and requests
   a_force_reads_zero: assert property (s_csr_read |=> !rdata[pwmart_pkg::CSR_FORCE])
      else $error("force reload bit read back as one");
   a_oe_follows: assert property (wr_stb && addr == pwmart_pkg::ADDR_PWM_CTRL
      |=> pwm_output_oe_n == ~$past(wdata[7:4])) else $error("output enable not as written");
   a_off_pin_low: assert property ((pwm_output_pin & pwm_output_oe_n) == 4'h0)
      else $error("disabled channel drives high");
   a_halt_freeze: assert property ($past(halt_mode) && !$past(wr_stb) && !$past(rst)
      |-> $stable(pwm_output_pin)) else $error("pwm moved during halt");
   a_ovf_irq_holds: assert property ($fell(overflow_irq) |-> s_access)
      else $error("overflow request dropped on its own");
   a_cap_irq_holds: assert property (|($past(capture_irq) & ~capture_irq) |-> s_access)
      else $error("capture request dropped on its own");
   a_wake_in_halt: assert property (capture_wakeup |-> $past(halt_mode) || $past(halt_mode, 2))
      else $error("wake-up outside halt");
   a_wake_pulse: assert property (capture_wakeup |=> !capture_wakeup)
      else $error("wake-up longer than one cycle");
endmodule

bind pwmart_top pwmart_sva u_sva (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .halt_mode(halt_mode),
   .pwm_output_pin(pwm_output_pin), .pwm_output_oe_n(pwm_output_oe_n),
   .overflow_irq(overflow_irq), .capture_irq(capture_irq), .capture_wakeup(capture_wakeup));

/* File: testbench/pwmart_top_bench.sv */
`timescale 1ns/100ps
// self-checking bench for the timer top
module pwmart_top_bench;
   localparam logic [3:0] A_CSR = pwmart_pkg::ADDR_CTRL_STATUS;
   localparam logic [3:0] A_CNT = pwmart_pkg::ADDR_COUNTER;
   localparam logic [3:0] A_RLD = pwmart_pkg::ADDR_RELOAD;
   localparam logic [3:0] A_PWM = pwmart_pkg::ADDR_PWM_CTRL;
   localparam logic [3:0] A_CAP = pwmart_pkg::ADDR_CAP_CTRL;
   logic mclk, rst, wr_stb, rd_stb, halt_mode, external_count_clock, overflow_irq, capture_wakeup;
   logic [3:0] addr, pwm_output_pin, pwm_output_oe_n;
   logic [7:0] wdata, rdata, v;
   logic [1:0] capture_input_pin, capture_irq;
   int bad_count, n_checks, wakes, hi[4], ri[4];
   pwmart_top u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .halt_mode(halt_mode),
      .external_count_clock(external_count_clock), .capture_input_pin(capture_input_pin),
      .pwm_output_pin(pwm_output_pin), .pwm_output_oe_n(pwm_output_oe_n),
      .overflow_irq(overflow_irq), .capture_irq(capture_irq), .capture_wakeup(capture_wakeup));
   pwmart_pins u_pins (.mclk(mclk), .ext_clk(external_count_clock), .cap(capture_input_pin));
   // 50 MHz clock
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   // wake-up pulses counted as they pass
   always @(posedge mclk) if (capture_wakeup === 1'h1) wakes++;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // bus cycles: strobe taken at the second edge
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'h1;
      @(posedge mclk);
      wr_stb <= 1'h0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'h1;
      @(posedge mclk);
      rd_stb <= 1'h0;
      #1 v = rdata;
   endtask
   task wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // high time and rising edges of every pin over twenty cycles
   task meas;
      logic [3:0] p;
      #1 p = pwm_output_pin;
      hi = '{0, 0, 0, 0};
      ri = '{0, 0, 0, 0};
      repeat (20) begin
         @(posedge mclk);
         #1;
         foreach (hi[i]) begin
            hi[i] += pwm_output_pin[i];
            ri[i] += pwm_output_pin[i] & !p[i];
         end
         p = pwm_output_pin;
      end
   endtask
   // every place reads zero after reset, unmapped ones included
   task t_reset;
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0]);
         chk(v, 8'h00);
      end
      $display("reset test done");
   endtask
   // four ticks at each tap, then the count stays frozen
   task t_div;
      for (int n = 0; n < 8; n++) begin
         wr(A_CNT, 8'h10);
         wr(A_CSR, {1'h0, n[2:0], 4'h8});
         wt((4 << n) - 2);
         wr(A_CSR, 8'h00);
         wt(9);
         rd(A_CNT);
         chk(v, 8'h14);
      end
      $display("divider test done");
   endtask
   // five-count period, duty FC..FF, then polarity, halt, overflow, reload
   task t_pwm;
      wr(A_RLD, 8'hFB);
      for (int i = 0; i < 4; i++) wr(pwmart_pkg::ADDR_DUTY0 - i[3:0], 8'hFC + i[7:0]);
      wr(A_PWM, 8'hF0);
      wr(A_CSR, 8'h0E);
      wt(12);
      meas();
      chk(pwm_output_oe_n, 4'h0);
      chk(overflow_irq, 1'h1);
      for (int i = 0; i < 4; i++) begin
         chk(hi[i], 4 * (i + 1));
         chk(ri[i], 4);
      end
      wr(A_PWM, 8'hFF);
      meas();
      for (int i = 0; i < 4; i++) chk(hi[i], 16 - 4 * i);
      @(posedge mclk) halt_mode <= 1'h1;
      meas();
      for (int i = 0; i < 4; i++) chk(ri[i], 0);
      @(posedge mclk) halt_mode <= 1'h0;
      wr(A_PWM, 8'h0F);
      wr(A_CSR, 8'h02);
      rd(A_CSR);
      chk(v, 8'h03);
      wt(3);
      chk(overflow_irq, 1'h0);
      chk(pwm_output_oe_n, 4'hF);
      wr(A_CSR, 8'h06);
      rd(A_CSR);
      chk(v, 8'h02);
      rd(A_CNT);
      chk(v, 8'hFB);
      // reload zero gives the full 256-count period
      wr(A_RLD, 8'h00);
      wr(A_CSR, 8'h0C);
      wt(253);
      rd(A_CNT);
      chk(v, 8'hFE);
      rd(A_CSR);
      chk(v, 8'h09);
      wr(A_CSR, 8'h00);
      $display("pwm test done");
   endtask
   // three external events from FD give one overflow
   task t_ext;
      wr(A_RLD, 8'hFD);
      wr(A_CNT, 8'hFD);
      wr(A_CSR, 8'h88);
      rd(A_CSR);
      chk(v, 8'h88);
      u_pins.pulse(2);
      wt(8);
      rd(A_CNT);
      chk(v, 8'hFF);
      u_pins.pulse(1);
      wt(8);
      rd(A_CSR);
      chk(v, 8'h89);
      rd(A_CNT);
      chk(v, 8'hFD);
      $display("external clock test done");
   endtask
   // capture, blocked second capture, read clear, wake-up in halt
   task t_cap;
      wr(A_CSR, 8'h00);
      wr(A_CNT, 8'h42);
      wr(A_CAP, 8'h14);
      u_pins.set_cap(0, 1'h1);
      wt(4);
      chk(capture_irq, 2'h1);
      rd(A_CAP);
      chk(v, 8'h15);
      wr(A_CNT, 8'h43);
      u_pins.set_cap(0, 1'h0);
      u_pins.set_cap(0, 1'h1);
      wt(4);
      rd(pwmart_pkg::ADDR_CAP1);
      chk(v, 8'h42);
      wt(3);
      chk(capture_irq, 2'h0);
      @(posedge mclk) halt_mode <= 1'h1;
      wr(A_CAP, 8'h08);
      wakes = 0;
      u_pins.set_cap(1, 1'h1);
      u_pins.set_cap(1, 1'h0);
      wt(6);
      chk(wakes, 1);
      rd(pwmart_pkg::ADDR_CAP2);
      chk(v, 8'h43);
      @(posedge mclk) halt_mode <= 1'h0;
      $display("capture test done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog well beyond the fewer than two thousand cycles the tests need
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
   // reset for six cycles, then the scenarios
   initial begin
      rst = 1'h1;
      wr_stb = 1'h0;
      rd_stb = 1'h0;
      addr = 4'h0;
      wdata = 8'h00;
      halt_mode = 1'h0;
      bad_count = 0;
      n_checks = 0;
      wakes = 0;
      wt(6);
      rst <= 1'h0;
      t_reset();
      t_div();
      t_pwm();
      t_ext();
      t_cap();
      finish_test();
   end
endmodule

/* File: verilog/pwmart_edge.sv */
`timescale 1ns/100ps
// two-stage synchroniser with edge detection on the second stage
module pwmart_edge (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pin side
   input wire logic pin_in,
   // edge pulses
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } pwmart_edge_st_t;
   pwmart_edge_st_t st_reg, st_next;

   // first stage feeds only the second
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise = st_reg.s2 & ~st_reg.s3;
   assign fall = ~st_reg.s2 & st_reg.s3;
endmodule

/* File: verilog/pwmart_pkg.sv */
package pwmart_pkg;
   // register offsets (port address, 4 bits)
   localparam logic [3:0] ADDR_DUTY3 = 4'h3;
   localparam logic [3:0] ADDR_DUTY2 = 4'h4;
   localparam logic [3:0] ADDR_DUTY1 = 4'h5;
   localparam logic [3:0] ADDR_DUTY0 = 4'h6;
   localparam logic [3:0] ADDR_PWM_CTRL = 4'h7;
   localparam logic [3:0] ADDR_CTRL_STATUS = 4'h8;
   localparam logic [3:0] ADDR_COUNTER = 4'h9;
   localparam logic [3:0] ADDR_RELOAD = 4'hA;
   localparam logic [3:0] ADDR_CAP_CTRL = 4'hB;
   localparam logic [3:0] ADDR_CAP1 = 4'hC;
   localparam logic [3:0] ADDR_CAP2 = 4'hD;
   // control/status field positions
   localparam int CSR_EXT_CLK = 7;
   localparam int CSR_DIV_HI = 6;
   localparam int CSR_DIV_LO = 4;
   localparam int CSR_RUN = 3;
   localparam int CSR_FORCE = 2;
   localparam int CSR_OVF_IE = 1;
   localparam int CSR_OVF = 0;
   // capture control field positions
   localparam int CAP_EDGE_LO = 4;
   localparam int CAP_IE_LO = 2;
   localparam int CAP_FLAG_LO = 0;
   // reset values and counts
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hFF;
   localparam int NUM_PWM = 4;
   localparam int NUM_CAP = 2;
   localparam int PRESC_BITS = 7;
endpackage

/* File: verilog/pwmart_top.sv */
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Behaviour
// - seven-bit prescaler with eight taps divides the input clock by 2^n
// - prescaler input is cpu clock or external count clock by select bit
// - divider field codes 0..7 give ratios 1 through 128
// - run enable low freezes prescaler and counter; high lets counter advance
// - reset clears counter, prescaler and selects cpu clock
// - force reload is write-only, reads zero, loads reload value, clears prescaler
// - counter write loads counter and clears prescaler; prescaler not accessible
// - each channel's hidden compare copied from duty buffer on overflow
// - output enable drives the pin push-pull with channel pwm
// - pwm frequency is tick rate over 256 minus reload value
// - overflow sets each pwm output to the inverse of its polarity level
// - counter reaching compare restores the opposite level
// - pwm generation stops during halt
// - overflow sets flag; interrupt request when enable also set
// - external clock: flag after 256 minus reload input events at divider code 0
// - selected capture edge latches counter and sets capture flag
// - capture register blocked until read clears the flag
// - capture irq holds while flag and enable are both set
// - in halt a selected capture edge gives wake-up when enabled
// - overflow reloads counter from reload value, prescaler untouched
// - reading control/status clears overflow flag; marks FFh to reload
// - reading a capture register clears its flag
// - changing polarity bit inverts the current output at once
module pwmart_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   // system state
   input wire logic halt_mode,
   // pins
   input wire logic external_count_clock,
   input wire logic [1:0] capture_input_pin,
   output logic [3:0] pwm_output_pin,
   output logic [3:0] pwm_output_oe_n,
   // interrupt requests
   output logic overflow_irq,
   output logic [1:0] capture_irq,
   output logic capture_wakeup
);
   typedef struct packed {
      logic ext_clock_select;
      logic [2:0] counter_clock_divider_select;
      logic counter_run_enable;
      logic overflow_irq_enable;
      logic overflow_flag;
      logic [6:0] presc;
      logic [7:0] counter;
      logic [7:0] auto_reload_value;
      logic [3:0][7:0] duty_cycle_buffer;
      logic [3:0][7:0] hidden_compare_value;
      logic [3:0] output_enable_bit;
      logic [3:0] output_polarity_bit;
      logic [3:0] pwm_raw;
      logic [1:0] capture_edge_select;
      logic [1:0] capture_irq_enable;
      logic [1:0] capture_flag;
      logic [1:0][7:0] capture_value;
      logic [7:0] rdata;
      logic [3:0] pin;
      logic [3:0] oe_n;
      logic ovf_irq;
      logic [1:0] cap_irq;
      logic wake;
   } pwmart_st_t;
   pwmart_st_t st_reg, st_next;

   logic ext_rise;
   logic [1:0] cap_rise;
   logic [1:0] cap_fall;

   pwmart_edge u_ext (
      .mclk(mclk),
      .rst(rst),
      .pin_in(external_count_clock),
      .rise(ext_rise),
      .fall()
   );

   // one synchroniser per capture input
   genvar gi;
   generate
      for (gi = 0; gi < pwmart_pkg::NUM_CAP; gi++) begin : g_cap
         pwmart_edge u_cap (
            .mclk(mclk),
            .rst(rst),
            .pin_in(capture_input_pin[gi]),
            .rise(cap_rise[gi]),
            .fall(cap_fall[gi])
         );
      end
   endgenerate

   // whole block next state
   always_comb begin
      logic in_tick;
      logic tap;
      logic tick;
      logic ovf;
      logic [6:0] presc_inc;
      logic [6:0] tap_mask;
      logic [1:0] cap_evt;
      logic wr_csr;
      logic wr_cnt;
      logic force_ld;
      logic [3:0] pol_flip;
      in_tick = 1'b0;
      tap = 1'b0;
      tick = 1'b0;
      ovf = 1'b0;
      presc_inc = 7'h00;
      tap_mask = 7'h00;
      cap_evt = 2'b00;
      wr_csr = wr_stb && (addr == pwmart_pkg::ADDR_CTRL_STATUS);
      wr_cnt = wr_stb && (addr == pwmart_pkg::ADDR_COUNTER);
      force_ld = wr_csr && wdata[pwmart_pkg::CSR_FORCE];
      pol_flip = 4'h0;
      st_next = st_reg;

      in_tick = st_reg.ext_clock_select ? ext_rise : 1'b1;
      if (!st_reg.counter_run_enable) begin
         in_tick = 1'b0;
      end
      presc_inc = st_reg.presc + 7'h01;
      // tap n carries out of the low n bits; code 0 gives an empty mask
      tap_mask = 7'h7F >> (3'd7 - st_reg.counter_clock_divider_select);
      tap = (st_reg.presc & tap_mask) == tap_mask;
      tick = in_tick && tap;
      if (in_tick) begin
         st_next.presc = presc_inc;
      end

      if (tick) begin
         // period of 256 minus reload ticks
         if (st_reg.counter == pwmart_pkg::COUNT_TOP) begin
            ovf = 1'b1;
            st_next.counter = st_reg.auto_reload_value;
         end else begin
            st_next.counter = st_reg.counter + 8'h01;
         end
      end

      if (ovf) begin
         st_next.hidden_compare_value = st_reg.duty_cycle_buffer;
      end

      // register writes
      if (wr_stb) begin
         unique case (addr)
            pwmart_pkg::ADDR_DUTY3: st_next.duty_cycle_buffer[3] = wdata;
            pwmart_pkg::ADDR_DUTY2: st_next.duty_cycle_buffer[2] = wdata;
            pwmart_pkg::ADDR_DUTY1: st_next.duty_cycle_buffer[1] = wdata;
            pwmart_pkg::ADDR_DUTY0: st_next.duty_cycle_buffer[0] = wdata;
            pwmart_pkg::ADDR_PWM_CTRL: begin
               st_next.output_enable_bit = wdata[7:4];
               pol_flip = wdata[3:0] ^ st_reg.output_polarity_bit;
               st_next.output_polarity_bit = wdata[3:0];
            end
            pwmart_pkg::ADDR_CTRL_STATUS: begin
               st_next.ext_clock_select = wdata[pwmart_pkg::CSR_EXT_CLK];
               st_next.counter_clock_divider_select =
                  wdata[pwmart_pkg::CSR_DIV_HI:pwmart_pkg::CSR_DIV_LO];
               st_next.counter_run_enable = wdata[pwmart_pkg::CSR_RUN];
               st_next.overflow_irq_enable = wdata[pwmart_pkg::CSR_OVF_IE];
            end
            pwmart_pkg::ADDR_RELOAD: st_next.auto_reload_value = wdata;
            pwmart_pkg::ADDR_CAP_CTRL: begin
               st_next.capture_edge_select = wdata[pwmart_pkg::CAP_EDGE_LO +: 2];
               st_next.capture_irq_enable = wdata[pwmart_pkg::CAP_IE_LO +: 2];
            end
            default: begin
            end
         endcase
      end
      if (wr_cnt) begin
         st_next.counter = wdata;
         st_next.presc = 7'h00;
      end
      if (force_ld) begin
         st_next.counter = st_reg.auto_reload_value;
         st_next.presc = 7'h00;
      end

      // read clears flag; set wins over clear
      if (rd_stb && addr == pwmart_pkg::ADDR_CTRL_STATUS) begin
         st_next.overflow_flag = 1'b0;
      end
      if (ovf) begin
         st_next.overflow_flag = 1'b1;
      end

      // capture flags and latches
      for (int c = 0; c < pwmart_pkg::NUM_CAP; c++) begin
         cap_evt[c] = st_reg.capture_edge_select[c] ? cap_rise[c] : cap_fall[c];
         // read of capture register clears flag
         if (rd_stb && addr == (c == 0 ? pwmart_pkg::ADDR_CAP1 : pwmart_pkg::ADDR_CAP2)) begin
            st_next.capture_flag[c] = 1'b0;
         end
         if (cap_evt[c] && !st_reg.capture_flag[c]) begin
            st_next.capture_value[c] = st_reg.counter;
            st_next.capture_flag[c] = 1'b1;
         end
      end

      // pwm levels, frozen in halt except for a polarity change
      for (int p = 0; p < pwmart_pkg::NUM_PWM; p++) begin
         if (!halt_mode) begin
            if (ovf) begin
               // polarity 0 starts the period high
               st_next.pwm_raw[p] = ~st_reg.output_polarity_bit[p];
            end else if (tick && st_next.counter == st_reg.hidden_compare_value[p]) begin
               st_next.pwm_raw[p] = st_reg.output_polarity_bit[p];
            end
         end
         if (pol_flip[p]) begin
            st_next.pwm_raw[p] = ~st_next.pwm_raw[p];
         end
      end
      st_next.pin = st_next.pwm_raw & st_next.output_enable_bit;
      st_next.oe_n = ~st_next.output_enable_bit;

      st_next.ovf_irq = st_next.overflow_flag & st_next.overflow_irq_enable;
      st_next.cap_irq = st_next.capture_flag & st_next.capture_irq_enable;
      st_next.wake = halt_mode && |(cap_evt & st_reg.capture_irq_enable);

      // read data, one cycle later; unmapped reads zero
      st_next.rdata = pwmart_pkg::RESET_BYTE;
      if (rd_stb) begin
         unique case (addr)
            pwmart_pkg::ADDR_DUTY3: st_next.rdata = st_reg.duty_cycle_buffer[3];
            pwmart_pkg::ADDR_DUTY2: st_next.rdata = st_reg.duty_cycle_buffer[2];
            pwmart_pkg::ADDR_DUTY1: st_next.rdata = st_reg.duty_cycle_buffer[1];
            pwmart_pkg::ADDR_DUTY0: st_next.rdata = st_reg.duty_cycle_buffer[0];
            pwmart_pkg::ADDR_PWM_CTRL:
               st_next.rdata = {st_reg.output_enable_bit, st_reg.output_polarity_bit};
            pwmart_pkg::ADDR_CTRL_STATUS:
               st_next.rdata = {st_reg.ext_clock_select, st_reg.counter_clock_divider_select,
                                st_reg.counter_run_enable, 1'b0,
                                st_reg.overflow_irq_enable, st_reg.overflow_flag};
            pwmart_pkg::ADDR_COUNTER: st_next.rdata = st_reg.counter;
            pwmart_pkg::ADDR_RELOAD: st_next.rdata = st_reg.auto_reload_value;
            pwmart_pkg::ADDR_CAP_CTRL:
               st_next.rdata = {2'b00, st_reg.capture_edge_select,
                                st_reg.capture_irq_enable, st_reg.capture_flag};
            pwmart_pkg::ADDR_CAP1: st_next.rdata = st_reg.capture_value[0];
            pwmart_pkg::ADDR_CAP2: st_next.rdata = st_reg.capture_value[1];
            default: st_next.rdata = pwmart_pkg::RESET_BYTE;
         endcase
      end
   end

   // reset clears all but oe_n, which goes high; cpu clock selected
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.oe_n <= 4'hF;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign rdata = st_reg.rdata;
   assign pwm_output_pin = st_reg.pin;
   assign pwm_output_oe_n = st_reg.oe_n;
   assign overflow_irq = st_reg.ovf_irq;
   assign capture_irq = st_reg.cap_irq;
   assign capture_wakeup = st_reg.wake;
endmodule
